// *** design/t16oc_pkg.sv ***
// Constants, register map and carrier types of the 16-bit timer compare block
package t16oc_pkg;
	localparam logic [3:0] ADR_CTRL = 4'h0;
	localparam logic [3:0] ADR_FORCE = 4'h1;
	localparam logic [3:0] ADR_CNT_L = 4'h2;
	localparam logic [3:0] ADR_CNT_H = 4'h3;
	localparam logic [3:0] ADR_CMPA_L = 4'h4;
	localparam logic [3:0] ADR_CMPA_H = 4'h5;
	localparam logic [3:0] ADR_CMPB_L = 4'h6;
	localparam logic [3:0] ADR_CMPB_H = 4'h7;
	localparam logic [3:0] ADR_MASK = 4'h8;
	localparam logic [3:0] ADR_FLAGS = 4'h9;
	localparam int F_WGM = 0;
	localparam int F_COMA = 4;
	localparam int F_COMB = 6;
	localparam int F_OVF = 0;
	localparam int F_CMPA = 1;
	localparam logic [3:0] WGM_NORMAL = 4'h0;
	localparam logic [3:0] WGM_CTC_OCR = 4'h4;
	localparam logic [3:0] WGM_CTC_CAP = 4'hc;
	localparam logic [3:0] WGM_RSVD = 4'hd;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [15:0] TOP_8BIT = 16'h00ff;
	localparam logic [15:0] TOP_9BIT = 16'h01ff;
	localparam logic [15:0] TOP_10BIT = 16'h03ff;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR = 2'h2;
	localparam logic [1:0] COM_SET = 2'h3;
	localparam logic [15:0] RST_CNT = 16'h0000;
	localparam logic [15:0] RST_CMP = 16'h0000;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [3:0] addr;
		logic [7:0] wdata;
	} t16oc_bus_s;

	typedef struct packed {
		logic [15:0] cnt;
		logic [7:0] temp;
		logic [1:0][15:0] ocr;
		logic [1:0][15:0] obuf;
		logic [3:0] wgm;
		logic [1:0][1:0] com;
		logic [1:0] cflag;
		logic [1:0] cen;
		logic ovf;
		logic ovf_en;
		logic [1:0] wave;
		logic blk;
		logic [7:0] rdata;
		logic [1:0] irq_cmp;
		logic irq_ovf;
		logic [1:0] pin_o;
		logic [1:0] pin_oe;
	} t16oc_state_s;
endpackage : t16oc_pkg

// *** design/t16oc.sv ***
// Output compare units A and B with counter and 8-bit register port
//
// The register offsets and the address-and-strobe port were decided locally.
module t16oc
	import t16oc_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Register port
	input wire t16oc_bus_s bus_req,
	output logic [7:0] bus_rdata,
	// Prescaled timer tick, one cycle pulse
	input wire logic timer_tick,
	// Interrupt service acknowledges
	input wire logic [1:0] irq_ack_cmp,
	input wire logic irq_ack_ovf,
	// General port value and direction of the wave pins
	input wire logic [1:0] port_val,
	input wire logic [1:0] port_dir,
	// Interrupt requests
	output logic [1:0] irq_cmp,
	output logic irq_ovf,
	// Wave pins
	output logic [1:0] pin_o,
	output logic [1:0] pin_oe
);
	t16oc_state_s st;
	t16oc_state_s nx;
	logic pwm;
	logic fast;
	logic hit_top;
	logic [15:0] top;
	logic [1:0] match;
	logic [1:0][15:0] cmp_view;

	function automatic logic act(input logic [1:0] com, input logic w);
		unique case (com)
			COM_TOGGLE: act = ~w;
			COM_CLEAR: act = 1'b0;
			COM_SET: act = 1'b1;
			default: act = w;
		endcase
	endfunction : act

	// Capture-defined TOP lives outside this block, so those modes run to max
	always_comb
	begin
		unique case (st.wgm)
			4'h1, 4'h5: top = TOP_8BIT;
			4'h2, 4'h6: top = TOP_9BIT;
			4'h3, 4'h7: top = TOP_10BIT;
			4'h4, 4'h9, 4'hb, 4'hf: top = st.ocr[0];
			default: top = CNT_MAX;
		endcase
	end

	assign pwm = !(st.wgm inside {WGM_NORMAL, WGM_CTC_OCR, WGM_CTC_CAP,
		WGM_RSVD});
	assign fast = st.wgm inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf};
	assign hit_top = st.cnt == top;
	assign cmp_view[0] = pwm ? st.obuf[0] : st.ocr[0];
	assign cmp_view[1] = pwm ? st.obuf[1] : st.ocr[1];

	// A counter write blocks the next tick's matches
	assign match[0] = (st.cnt == st.ocr[0]) && !st.blk;
	assign match[1] = (st.cnt == st.ocr[1]) && !st.blk;

	always_comb
	begin
		logic [1:0] clr;
		logic sel;
		clr = irq_ack_cmp;
		nx = st;
		sel = 1'b0;
		if (bus_req.wr && bus_req.addr == ADR_FLAGS)
		begin
			clr = clr | bus_req.wdata[F_CMPA +: 2];
		end
		nx.cflag = st.cflag & ~clr;
		if (irq_ack_ovf || (bus_req.wr && bus_req.addr == ADR_FLAGS &&
			bus_req.wdata[F_OVF]))
		begin
			nx.ovf = 1'b0;
		end
		// Counting depends on mode bits and compare A only, never on output actions
		if (timer_tick)
		begin
			nx.blk = 1'b0;
			// Dual-slope sequences are not modelled: all modes count up
			nx.cnt = hit_top ? RST_CNT : st.cnt + 16'h0001;
			if (pwm ? hit_top : st.cnt == CNT_MAX)
			begin
				nx.ovf = 1'b1;
			end
			for (int u = 0; u < 2; u++)
			begin
				if (match[u])
				begin
					nx.cflag[u] = 1'b1;
					if (!pwm)
					begin
						nx.wave[u] = act(st.com[u], st.wave[u]);
					end
					else if (fast && st.com[u][1])
					begin
						nx.wave[u] = st.com[u][0];
					end
				end
				// Bottom edge wins over the match so compare at TOP stays steady
				if (fast && hit_top && st.com[u][1])
				begin
					nx.wave[u] = ~st.com[u][0];
				end
				if (pwm && hit_top)
				begin
					nx.ocr[u] = st.obuf[u];
				end
			end
		end
		nx.rdata = 8'h00;
		if (bus_req.wr)
		begin
			unique case (bus_req.addr)
				ADR_CTRL:
				begin
					nx.wgm = bus_req.wdata[F_WGM +: 4];
					nx.com[0] = bus_req.wdata[F_COMA +: 2];
					nx.com[1] = bus_req.wdata[F_COMB +: 2];
				end
				ADR_FORCE:
				begin
					for (int u = 0; u < 2; u++)
					begin
						if (!pwm && bus_req.wdata[u])
						begin
							nx.wave[u] = act(st.com[u], st.wave[u]);
						end
					end
				end
				ADR_CNT_L:
				begin
					nx.cnt = {st.temp, bus_req.wdata};
					nx.blk = 1'b1;
				end
				ADR_CNT_H, ADR_CMPA_H, ADR_CMPB_H:
				begin
					nx.temp = bus_req.wdata;
				end
				ADR_CMPA_L, ADR_CMPB_L:
				begin
					sel = bus_req.addr == ADR_CMPB_L;
					if (pwm)
					begin
						nx.obuf[sel] = {st.temp, bus_req.wdata};
					end
					else
					begin
						nx.ocr[sel] = {st.temp, bus_req.wdata};
					end
				end
				ADR_MASK:
				begin
					nx.ovf_en = bus_req.wdata[F_OVF];
					nx.cen = bus_req.wdata[F_CMPA +: 2];
				end
				default:
				begin
				end
			endcase
		end
		if (bus_req.rd)
		begin
			unique case (bus_req.addr)
				ADR_CTRL: nx.rdata = {st.com[1], st.com[0], st.wgm};
				ADR_CNT_L:
				begin
					nx.rdata = st.cnt[7:0];
					nx.temp = st.cnt[15:8];
				end
				ADR_CNT_H: nx.rdata = st.temp;
				ADR_CMPA_L: nx.rdata = cmp_view[0][7:0];
				ADR_CMPA_H: nx.rdata = cmp_view[0][15:8];
				ADR_CMPB_L: nx.rdata = cmp_view[1][7:0];
				ADR_CMPB_H: nx.rdata = cmp_view[1][15:8];
				ADR_MASK: nx.rdata = {5'h00, st.cen, st.ovf_en};
				ADR_FLAGS: nx.rdata = {5'h00, st.cflag, st.ovf};
				default: nx.rdata = 8'h00;
			endcase
		end
		nx.irq_cmp = nx.cflag & nx.cen;
		nx.irq_ovf = nx.ovf & nx.ovf_en;
		for (int u = 0; u < 2; u++)
		begin
			nx.pin_o[u] = (nx.com[u] != 2'h0) ? nx.wave[u] : port_val[u];
		end
		nx.pin_oe = port_dir;
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			st <= '0;
		end
		else
		begin
			st <= nx;
		end
	end

	assign bus_rdata = st.rdata;
	assign irq_cmp = st.irq_cmp;
	assign irq_ovf = st.irq_ovf;
	assign pin_o = st.pin_o;
	assign pin_oe = st.pin_oe;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	logic cnt_wr;
	logic flag_wr;
	assign cnt_wr = bus_req.wr && bus_req.addr == ADR_CNT_L;
	assign flag_wr = bus_req.wr && bus_req.addr == ADR_FLAGS;

	sequence s_tick_wrap;
		timer_tick && st.wgm == WGM_NORMAL && st.cnt == CNT_MAX && !cnt_wr;
	endsequence

	sequence s_zero_ovf;
		st.cnt == 16'h0000 && st.ovf;
	endsequence

	normal_wrap_a: assert property (s_tick_wrap |=> s_zero_ovf)
		else $error("normal mode did not wrap with overflow");

	sequence s_ovf_event;
		timer_tick && (pwm ? hit_top : st.cnt == CNT_MAX);
	endsequence

	sequence s_quiet_cnt;
		!timer_tick && !cnt_wr;
	endsequence

	sequence s_top_step;
		timer_tick && hit_top && !cnt_wr;
	endsequence

	ovf_set_a: assert property (s_ovf_event |=> st.ovf)
		else $error("overflow event did not set overflow flag");

	// Set wins, so the clear is only checked away from an overflow event
	ovf_ack_a: assert property (irq_ack_ovf &&
		!(timer_tick && (pwm ? hit_top : st.cnt == CNT_MAX)) |=> !st.ovf)
		else $error("service acknowledge did not clear overflow flag");

	ovf_irq_a: assert property (st.ovf && st.ovf_en |-> irq_ovf)
		else $error("overflow irq missing while flag and enable set");

	cnt_hold_a: assert property (s_quiet_cnt |=> $stable(st.cnt))
		else $error("counter moved without tick or write");

	cnt_step_a: assert property (timer_tick && !cnt_wr &&
		!hit_top |=> st.cnt == $past(st.cnt) + 16'h0001)
		else $error("counter did not step up by one");

	top_wrap_a: assert property (s_top_step |=> st.cnt == RST_CNT)
		else $error("counter did not restart after TOP");

	cnt_load_a: assert property (cnt_wr |=>
		st.cnt == {$past(st.temp), $past(bus_req.wdata)})
		else $error("counter write did not load all 16 bits");

	// Enable is copied straight through, one register late
	oe_follow_a: assert property (##1 pin_oe == $past(port_dir))
		else $error("pin enable does not follow port direction");

	genvar g;
	for (g = 0; g < 2; g++)
	begin : g_chk
		flag_set_a: assert property (timer_tick && match[g] |=>
			st.cflag[g])
			else $error("match did not set compare flag");
		irq_level_a: assert property (st.cflag[g] && st.cen[g] |->
			irq_cmp[g])
			else $error("compare irq missing while flag and enable set");
		flag_clear_a: assert property (flag_wr &&
			bus_req.wdata[F_CMPA + g] && !(timer_tick && match[g]) |=>
			!st.cflag[g])
			else $error("write one did not clear compare flag");
		match_block_a: assert property (cnt_wr ##1 timer_tick &&
			!st.cflag[g] && st.cnt == st.ocr[g] |=> !st.cflag[g])
			else $error("match after counter write was not blocked");
		force_flag_a: assert property (bus_req.wr &&
			bus_req.addr == ADR_FORCE && bus_req.wdata[g] && !pwm &&
			st.com[g] == COM_TOGGLE && !timer_tick && !st.cflag[g] |=>
			st.wave[g] != $past(st.wave[g]) && !st.cflag[g])
			else $error("force strobe misbehaved");
		buf_hold_a: assert property (pwm && !(timer_tick && hit_top) |=>
			$stable(st.ocr[g]))
			else $error("active compare changed outside TOP");
		direct_wr_a: assert property (bus_req.wr && !pwm &&
			bus_req.addr == (g == 0 ? ADR_CMPA_L : ADR_CMPB_L) |=>
			st.ocr[g] == {$past(st.temp), $past(bus_req.wdata)})
			else $error("compare low write did not load all 16 bits");
		pin_mux_a: assert property (##1 pin_o[g] ==
			($past(nx.com[g]) != 2'h0 ? $past(nx.wave[g]) : $past(port_val[g])))
			else $error("pin source select wrong");
		hold_zero_a: assert property (timer_tick && match[g] &&
			st.com[g] == 2'h0 && !bus_req.wr |=> $stable(st.wave[g]))
			else $error("action zero changed wave bit");

		localparam logic [3:0] LO_ADR = (g == 0) ? ADR_CMPA_L : ADR_CMPB_L;
		localparam logic [3:0] HI_ADR = (g == 0) ? ADR_CMPA_H : ADR_CMPB_H;

		sequence s_fast_top;
			timer_tick && fast && hit_top && st.com[g][1];
		endsequence

		sequence s_buf_load;
			timer_tick && pwm && hit_top;
		endsequence

		sequence s_hi_read;
			bus_req.rd && !pwm && bus_req.addr == HI_ADR;
		endsequence

		ack_clear_a: assert property (irq_ack_cmp[g] &&
			!(timer_tick && match[g]) |=> !st.cflag[g])
			else $error("service acknowledge did not clear compare flag");
		buf_load_a: assert property (s_buf_load |=>
			st.ocr[g] == $past(st.obuf[g]))
			else $error("active compare not loaded from buffer at TOP");
		pwm_top_a: assert property (s_fast_top |=>
			st.wave[g] == ~$past(st.com[g][0]))
			else $error("fast PWM output wrong after TOP");
		obuf_keep_a: assert property (!(bus_req.wr &&
			bus_req.addr == LO_ADR) |=> $stable(st.obuf[g]))
			else $error("compare buffer changed without a write");
		// The only other way in is the buffer load at TOP
		ocr_keep_a: assert property (!(bus_req.wr &&
			bus_req.addr == LO_ADR) && !(timer_tick && pwm && hit_top) |=>
			$stable(st.ocr[g]))
			else $error("compare register changed without a write");
		hi_read_a: assert property (s_hi_read |=>
			bus_rdata == $past(st.ocr[g][15:8]))
			else $error("compare high read did not return register byte");
		wave_keep_a: assert property (bus_req.wr &&
			bus_req.addr == ADR_CTRL && !timer_tick |=>
			$stable(st.wave[g]))
			else $error("mode write changed wave bit");
		act_set_a: assert property (timer_tick && match[g] &&
			!pwm && st.com[g] == COM_SET |=> st.wave[g])
			else $error("set action did not set wave bit");
		act_clear_a: assert property (timer_tick && match[g] &&
			!pwm && st.com[g] == COM_CLEAR |=> !st.wave[g])
			else $error("clear action did not clear wave bit");
		act_toggle_a: assert property (timer_tick && match[g] &&
			!pwm && st.com[g] == COM_TOGGLE &&
			!(bus_req.wr && bus_req.addr == ADR_FORCE) |=>
			st.wave[g] != $past(st.wave[g]))
			else $error("toggle action did not toggle wave bit");
		// Force strobes are refused while a PWM mode runs
		force_pwm_a: assert property (bus_req.wr &&
			bus_req.addr == ADR_FORCE && pwm && !timer_tick |=>
			$stable(st.wave[g]))
			else $error("force strobe acted in PWM mode");
	end
endmodule : t16oc

// *** testbench/t16oc_cpu.sv ***
// CPU side model: one-cycle register port strobes
module t16oc_cpu
	import t16oc_pkg::*;
(
	// Clock
	input wire logic clk_sys,
	// Register port
	output t16oc_bus_s bus_req
);
	timeunit 1ns;
	timeprecision 1ns;
	initial bus_req = '0;
	// Idle address and data flip so stale values never look live
	task automatic cyc(input logic r, input logic [3:0] a, input logic [7:0] d);
	begin
		@(posedge clk_sys);
		bus_req <= '{rd: r, wr: !r, addr: a, wdata: d};
		@(posedge clk_sys);
		bus_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
	end
	endtask : cyc
endmodule : t16oc_cpu

// *** testbench/t16oc_tb.sv ***
// Self-checking bench of the timer compare block
module t16oc_tb
	import t16oc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	t16oc_bus_s bus_req;
	logic [7:0] bus_rdata;
	logic timer_tick = 1'b0;
	logic [1:0] irq_ack_cmp = 2'h0;
	logic irq_ack_ovf = 1'b0;
	logic [1:0] port_val = 2'h0;
	logic [1:0] port_dir = 2'h0;
	logic [1:0] irq_cmp;
	logic [1:0] pin_o;
	logic [1:0] pin_oe;
	logic irq_ovf;
	int error_cnt = 0;
	int checks_done = 0;
	logic [7:0] exp_q[$];
	logic rd_pend = 1'b0;
	logic [15:0] v;
	logic [1:0] pv;

	always #25 clk_sys = ~clk_sys;

	t16oc_cpu cpu (.clk_sys(clk_sys), .bus_req(bus_req));

	t16oc uut (
		.clk_sys(clk_sys), .rstn(rstn), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .timer_tick(timer_tick),
		.irq_ack_cmp(irq_ack_cmp), .irq_ack_ovf(irq_ack_ovf),
		.port_val(port_val), .port_dir(port_dir), .irq_cmp(irq_cmp),
		.irq_ovf(irq_ovf), .pin_o(pin_o), .pin_oe(pin_oe)
	);

	task automatic chk_rd(input logic [7:0] e, input logic [7:0] g);
	begin
		checks_done++;
		if (g !== e)
		begin
			$display("unexpected read data: expected %h, seen %h", e, g);
			error_cnt++;
		end
	end
	endtask : chk_rd

	task automatic chk_out(input string n, input logic [1:0] e,
		input logic [1:0] g);
	begin
		checks_done++;
		if (g !== e)
		begin
			$display("unexpected %s: expected %b, seen %b", n, e, g);
			error_cnt++;
		end
	end
	endtask : chk_out

	task automatic test_done;
	begin
		$display("checks %0d, mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask : test_done

	// Read data belongs to the cycle after the strobe only
	always @(posedge clk_sys)
	begin
		if (rd_pend)
			chk_rd(exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx, bus_rdata);
		rd_pend <= bus_req.rd;
	end

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		cpu.cyc(1'b0, a, d);
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
	begin
		exp_q.push_back(e);
		cpu.cyc(1'b1, a, 8'h00);
	end
	endtask : rd

	// High byte first; counter written only in normal mode
	task automatic w16(input logic [3:0] ah, input logic [15:0] d);
	begin
		wr(ah, d[15:8]);
		wr(ah - 4'h1, d[7:0]);
	end
	endtask : w16

	task automatic tick(input int n);
		repeat (n)
		begin
			@(posedge clk_sys) timer_tick <= 1'b1;
			@(posedge clk_sys) timer_tick <= 1'b0;
		end
	endtask : tick

	task automatic idle(input int n);
	begin
		repeat (n) @(posedge clk_sys);
		#1;
	end
	endtask : idle

	initial
	begin
		repeat (3000) @(posedge clk_sys);
		$display("unexpected run length: expected end, seen hang");
		error_cnt++;
		test_done();
	end

	initial
	begin
		void'($urandom(4331));
		pv = 2'($urandom);
		v = {4'h8, 12'($urandom)};
		repeat (3) @(posedge clk_sys);
		rstn <= 1'b1;
		port_val <= pv;
		port_dir <= 2'h3;
		wr(ADR_CTRL, {2'h0, COM_TOGGLE, WGM_NORMAL});
		idle(3);
		chk_out("wave pins", {pv[1], 1'b0}, pin_o);
		chk_out("pin enables", 2'h3, pin_oe);
		$display("test reset done");
		w16(ADR_CMPB_H, v);
		wr(ADR_CMPA_H, ~v[15:8]);
		rd(ADR_CMPB_L, v[7:0]);
		rd(ADR_CMPB_H, v[15:8]);
		$display("test compare access done");
		w16(ADR_CNT_H, 16'h0004);
		w16(ADR_CMPA_H, 16'h0005);
		wr(ADR_MASK, 8'h02);
		tick(1);
		rd(ADR_FLAGS, 8'h00);
		tick(1);
		rd(ADR_FLAGS, 8'h02);
		idle(2);
		chk_out("compare irq", 2'h1, irq_cmp);
		chk_out("wave pins", {pv[1], 1'b1}, pin_o);
		$display("test match done");
		wr(ADR_FLAGS, 8'h00);
		rd(ADR_FLAGS, 8'h02);
		wr(ADR_FLAGS, 8'h02);
		rd(ADR_FLAGS, 8'h00);
		w16(ADR_CNT_H, 16'h0004);
		tick(2);
		@(posedge clk_sys) irq_ack_cmp <= 2'h1;
		@(posedge clk_sys) irq_ack_cmp <= 2'h0;
		idle(2);
		chk_out("compare irq", 2'h0, irq_cmp);
		chk_out("wave pins", {pv[1], 1'b0}, pin_o);
		$display("test flag clear done");
		w16(ADR_CNT_H, 16'h0005);
		tick(2);
		rd(ADR_FLAGS, 8'h00);
		wr(ADR_FORCE, 8'h01);
		idle(2);
		chk_out("wave pins", {pv[1], 1'b1}, pin_o);
		rd(ADR_FLAGS, 8'h00);
		rd(ADR_CNT_L, 8'h07);
		$display("test block and force done");
		wr(ADR_CTRL, 8'h00);
		idle(2);
		chk_out("wave pins", pv, pin_o);
		w16(ADR_CNT_H, 16'h0004);
		tick(2);
		wr(ADR_CTRL, {2'h0, COM_TOGGLE, WGM_CTC_OCR});
		idle(2);
		chk_out("wave pins", {pv[1], 1'b1}, pin_o);
		wr(ADR_CTRL, {2'h0, COM_TOGGLE, WGM_NORMAL});
		w16(ADR_CNT_H, 16'h0004);
		tick(2);
		idle(2);
		chk_out("wave pins", {pv[1], 1'b0}, pin_o);
		wr(ADR_FLAGS, 8'h07);
		$display("test action modes done");
		wr(ADR_MASK, 8'h01);
		w16(ADR_CNT_H, 16'hfffe);
		tick(2);
		rd(ADR_CNT_L, 8'h00);
		rd(ADR_CNT_H, 8'h00);
		rd(ADR_FLAGS, 8'h01);
		idle(1);
		chk_out("overflow irq", 2'h1, {1'b0, irq_ovf});
		@(posedge clk_sys) irq_ack_ovf <= 1'b1;
		@(posedge clk_sys) irq_ack_ovf <= 1'b0;
		rd(ADR_FLAGS, 8'h00);
		idle(3);
		$display("test overflow done");
		wr(ADR_CTRL, {COM_SET, COM_CLEAR, 4'hf});
		w16(ADR_CMPA_H, 16'h0003);
		w16(ADR_CMPB_H, 16'h0002);
		rd(ADR_CMPA_L, 8'h03);
		tick(6);
		idle(2);
		chk_out("wave pins", 2'b01, pin_o);
		rd(ADR_CNT_L, 8'h00);
		rd(ADR_FLAGS, 8'h03);
		tick(3);
		idle(2);
		chk_out("wave pins", 2'b11, pin_o);
		wr(ADR_FORCE, 8'h03);
		idle(2);
		chk_out("wave pins", 2'b11, pin_o);
		$display("test fast pwm done");
		test_done();
	end
endmodule : t16oc_tb
